/* include/dmas_pkg.sv */
// Shared constants of the display memory access scheduler
package dmas_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_BMASK = 8'h04;
    localparam logic [7:0] OFS_FGPAT = 8'h08;
    localparam logic [7:0] OFS_BGPAT = 8'h0C;
    localparam logic [7:0] OFS_PPOS  = 8'h10;
    localparam logic [7:0] OFS_PIDX  = 8'h14;
    localparam logic [7:0] OFS_PROW  = 8'h18;
    localparam logic [7:0] OFS_STAT  = 8'h1C;
    localparam logic [7:0] OFS_PCOL  = 8'h20;
    // Control field positions
    localparam int CT_VRAM  = 0;
    localparam int CT_RES   = 1;
    localparam int CT_MEM16 = 3;
    localparam int CT_IO16  = 4;
    localparam int CT_FGBG  = 5;
    localparam int CT_SESS  = 6;
    localparam int CT_PTREN = 8;
    localparam int CT_W     = 9;
    // Resolution classes
    localparam logic [1:0] RES_STD  = 2'h0;
    localparam logic [1:0] RES_800  = 2'h1;
    localparam logic [1:0] RES_1024 = 2'h2;
    // Reset values
    localparam logic [8:0]  CTRL_RST  = 9'h000;
    localparam logic [11:0] BMASK_RST = 12'hFFF;
    localparam logic [31:0] PAT_RST   = 32'h0000_0000;
    localparam logic [7:0]  PCOL_RST  = 8'hFF;
    // Bus answers
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Pointer size and pixel buffer depth
    localparam int PTR_N    = 32;
    localparam int PIX_W    = 8;
    localparam int PIX_DEPTH = 2;
    typedef enum logic [1:0] {W_IDLE, W_LO, W_HI} dmas_wst_t;
endpackage

/* logic/dmas_buf.sv */
// Small FIFO with registered head, valid and ready on both sides
`timescale 1ns/10ps
module dmas_buf #(
    parameter int W = 8,
    parameter int D = 2
) (
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
        logic                irdy;
        logic                ov;
        logic [W-1:0]        od;
    } dmas_buf_t;
    dmas_buf_t q;
    dmas_buf_t n;
    logic      push;
    logic      pop;

    always_comb begin
        n = q;
        push = in_valid_i && q.irdy;
        pop = q.ov && out_ready_i;
        if (push) begin
            n.mem[q.wp] = in_data_i;
            n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        n.cnt = q.cnt + CW'(push) - CW'(pop);
        n.irdy = (n.cnt != CW'(D));
        n.ov = (n.cnt != '0);
        n.od = n.mem[n.rp];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.irdy <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign in_ready_o = q.irdy;
    assign out_valid_o = q.ov;
    assign out_data_o = q.od;
endmodule

/* logic/dmas_top.sv */
// Display memory scheduler, posted host writes, pointer overlay
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module dmas_top
    import dmas_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    input  wire logic [7:0]   s_axi_awaddr_i,
    input  wire logic         s_axi_awvalid_i,
    output logic              s_axi_awready_o,
    input  wire logic [31:0]  s_axi_wdata_i,
    input  wire logic [3:0]   s_axi_wstrb_i,
    input  wire logic         s_axi_wvalid_i,
    output logic              s_axi_wready_o,
    output logic [1:0]        s_axi_bresp_o,
    output logic              s_axi_bvalid_o,
    input  wire logic         s_axi_bready_i,
    input  wire logic [7:0]   s_axi_araddr_i,
    input  wire logic         s_axi_arvalid_i,
    output logic              s_axi_arready_o,
    output logic [31:0]       s_axi_rdata_o,
    output logic [1:0]        s_axi_rresp_o,
    output logic              s_axi_rvalid_o,
    input  wire logic         s_axi_rready_i,
    input  wire logic         disp_active_i,
    input  wire logic         cclk_tick_i,
    input  wire logic         refresh_req_i,
    input  wire logic         line_start_i,
    input  wire logic         reload_i,
    input  wire logic         host_wr_i,
    input  wire logic         host_word_i,
    input  wire logic [15:0]  host_addr_i,
    input  wire logic [15:0]  host_data_i,
    output logic              host_wait_o,
    output logic              host_mem16_o,
    output logic              host_io16_o,
    output logic              mem_we_o,
    output logic [17:0]       mem_addr_o,
    output logic [31:0]       mem_data_o,
    output logic [3:0]        mem_plane_o,
    output logic [7:0]        mem_bitmask_o,
    output logic              row_xfer_o,
    output logic              sclk_o,
    input  wire logic         pix_valid_i,
    input  wire logic [dmas_pkg::PIX_W-1:0] pix_data_i,
    input  wire logic [10:0]  pix_x_i,
    input  wire logic [10:0]  pix_y_i,
    output logic              pix_ready_o,
    output logic              pix_valid_o,
    output logic [dmas_pkg::PIX_W-1:0] pix_o,
    input  wire logic         pix_ready_i
);
    import dmas_pkg::*;

    typedef struct packed {
        logic                          awrdy;
        logic                          aw_ok;
        logic [7:0]                    awa;
        logic                          wrdy;
        logic                          w_ok;
        logic [31:0]                   wd;
        logic [3:0]                    ws;
        logic                          bv;
        logic [1:0]                    br;
        logic                          arrdy;
        logic                          rv;
        logic [31:0]                   rd;
        logic [1:0]                    rr;
        logic [CT_W-1:0]               ctrl;
        logic [11:0]                   bmask;
        logic [31:0]                   fg;
        logic [31:0]                   bg;
        logic [31:0]                   ppos;
        logic [4:0]                    pidx;
        logic [7:0]                    pcol;
        logic [PTR_N-1:0][PTR_N-1:0]   prow;
        logic [1:0]                    cc;
        logic                          rx_pend;
        dmas_wst_t                     wst;
        logic [15:0]                   wa;
        logic [15:0]                   wdat;
        logic                          hwait;
        logic                          we;
        logic [17:0]                   ma;
        logic [31:0]                   md;
        logic [3:0]                    mp;
        logic [7:0]                    mbm;
        logic                          rx;
        logic                          sclk;
    } dmas_st_t;

    dmas_st_t         q;
    dmas_st_t         n;
    logic             vram;
    logic [1:0]       res;
    logic [1:0]       rmask;
    logic             slot;
    logic             host_go;
    logic [7:0]       wbyte;
    logic [10:0]      dx;
    logic [10:0]      dy;
    logic             hit;
    logic [PIX_W-1:0] pix_mix;
    logic [31:0]      rsel;
    logic             rhit;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign vram = q.ctrl[CT_VRAM];
    assign res = q.ctrl[CT_RES +: 2];

    // Slot spacing per memory type and resolution
    always_comb begin
        if (!vram) begin
            rmask = (res == RES_800) ? 2'h3 : 2'h1;
        end else if (res == RES_STD) begin
            rmask = 2'h0;
        end else if (res == RES_800) begin
            rmask = 2'h1;
        end else begin
            rmask = 2'h3;
        end
    end

    // Active display: tick-paced slots; otherwise any non-refresh cycle
    assign slot = disp_active_i ? (cclk_tick_i && ((q.cc & rmask) == 2'h0))
                                : !refresh_req_i;
    assign host_go = slot && !q.rx_pend && (q.wst != W_IDLE);
    assign wbyte = (q.wst == W_HI) ? q.wdat[15:8] : q.wdat[7:0];

    // Pointer hit test
    assign dx = pix_x_i - q.ppos[10:0];
    assign dy = pix_y_i - q.ppos[26:16];
    assign hit = q.ctrl[CT_PTREN] && (dx < 11'h020) && (dy < 11'h020)
                 && q.prow[dy[4:0]][dx[4:0]];
    assign pix_mix = hit ? q.pcol : pix_data_i;

    // Read decode
    always_comb begin
        rhit = 1'b1;
        rsel = 32'h0000_0000;
        if (s_axi_araddr_i == OFS_CTRL) begin
            rsel = 32'(q.ctrl);
        end else if (s_axi_araddr_i == OFS_BMASK) begin
            rsel = 32'(q.bmask);
        end else if (s_axi_araddr_i == OFS_FGPAT) begin
            rsel = q.fg;
        end else if (s_axi_araddr_i == OFS_BGPAT) begin
            rsel = q.bg;
        end else if (s_axi_araddr_i == OFS_PPOS) begin
            rsel = q.ppos;
        end else if (s_axi_araddr_i == OFS_PIDX) begin
            rsel = 32'(q.pidx);
        end else if (s_axi_araddr_i == OFS_PROW) begin
            rsel = q.prow[q.pidx];
        end else if (s_axi_araddr_i == OFS_STAT) begin
            rsel = {27'h0, q.cc, q.rx_pend, q.hwait, vram};
        end else if (s_axi_araddr_i == OFS_PCOL) begin
            rsel = 32'(q.pcol);
        end else begin
            rhit = 1'b0;
        end
    end

    always_comb begin
        n = q;
        n.we = 1'b0;
        n.rx = 1'b0;
        n.sclk = 1'b0;
        // Write address and data taken in either order
        if (s_axi_awvalid_i && q.awrdy) begin
            n.aw_ok = 1'b1;
            n.awa = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wrdy) begin
            n.w_ok = 1'b1;
            n.wd = s_axi_wdata_i;
            n.ws = s_axi_wstrb_i;
        end
        if (q.aw_ok && q.w_ok && !q.bv) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bv = 1'b1;
            n.br = RESP_OK;
            if (q.awa == OFS_CTRL) begin
                n.ctrl = CT_W'(merge(32'(q.ctrl), q.wd, q.ws));
            end else if (q.awa == OFS_BMASK) begin
                n.bmask = 12'(merge(32'(q.bmask), q.wd, q.ws));
            end else if (q.awa == OFS_FGPAT) begin
                n.fg = merge(q.fg, q.wd, q.ws);
            end else if (q.awa == OFS_BGPAT) begin
                n.bg = merge(q.bg, q.wd, q.ws);
            end else if (q.awa == OFS_PPOS) begin
                n.ppos = merge(q.ppos, q.wd, q.ws);
            end else if (q.awa == OFS_PIDX) begin
                n.pidx = 5'(merge(32'(q.pidx), q.wd, q.ws));
            end else if (q.awa == OFS_PROW) begin
                n.prow[q.pidx] = merge(q.prow[q.pidx], q.wd, q.ws);
            end else if (q.awa == OFS_PCOL) begin
                n.pcol = 8'(merge(32'(q.pcol), q.wd, q.ws));
            end else if (q.awa != OFS_STAT) begin
                n.br = RESP_ERR;
            end
        end
        if (q.bv && s_axi_bready_i) begin
            n.bv = 1'b0;
        end
        n.awrdy = !n.aw_ok;
        n.wrdy = !n.w_ok;
        // Read channel
        if (s_axi_arvalid_i && q.arrdy) begin
            n.rv = 1'b1;
            n.rd = rsel;
            n.rr = rhit ? RESP_OK : RESP_ERR;
        end else if (q.rv && s_axi_rready_i) begin
            n.rv = 1'b0;
        end
        n.arrdy = !n.rv;

        // Character clock phase during active display
        if (!disp_active_i) begin
            n.cc = 2'h0;
        end else if (cclk_tick_i) begin
            n.cc = q.cc + 2'h1;
            n.sclk = vram;
        end
        // Row transfer owed at line start and mid-line reload, in VRAM mode only
        if (vram && (line_start_i || reload_i)) begin
            n.rx_pend = 1'b1;
        end else if (slot && q.rx_pend) begin
            n.rx_pend = 1'b0;
            n.rx = 1'b1;
        end

        // Posted host write path
        case (q.wst)
            W_IDLE: begin
                if (host_wr_i) begin
                    n.wa = host_addr_i;
                    n.wdat = host_data_i;
                    n.wst = W_LO;
                end
            end
            W_LO: begin
                if (host_go) begin
                    n.wst = (host_word_i && q.ctrl[CT_MEM16])
                            ? W_HI : W_IDLE;
                end
            end
            W_HI: begin
                if (host_go) begin
                    n.wst = W_IDLE;
                end
            end
            default: begin
                n.wst = W_IDLE;
            end
        endcase
        if (host_go) begin
            n.we = 1'b1;
            n.ma = {q.ctrl[CT_SESS +: 2],
                    q.wa + {15'h0000, q.wst == W_HI}};
            n.mp = q.bmask[11:8];
            n.mbm = vram ? q.bmask[7:0] : 8'hFF;
            for (int p = 0; p < 4; p++) begin
                if (q.ctrl[CT_FGBG]) begin
                    n.md[p*8 +: 8] = (wbyte & q.fg[p*8 +: 8])
                                   | (~wbyte & q.bg[p*8 +: 8]);
                end else begin
                    n.md[p*8 +: 8] = wbyte;
                end
            end
        end
        n.hwait = (n.wst != W_IDLE);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.awrdy <= 1'b1;
            q.wrdy <= 1'b1;
            q.arrdy <= 1'b1;
            q.ctrl <= CTRL_RST;
            q.bmask <= BMASK_RST;
            q.fg <= PAT_RST;
            q.bg <= PAT_RST;
            q.pcol <= PCOL_RST;
            q.wst <= W_IDLE;
        end else begin
            q <= n;
        end
    end

    dmas_buf #(
        .W (PIX_W),
        .D (PIX_DEPTH)
    ) u_pix_buf (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (pix_valid_i),
        .in_data_i   (pix_mix),
        .in_ready_o  (pix_ready_o),
        .out_valid_o (pix_valid_o),
        .out_data_o  (pix_o),
        .out_ready_i (pix_ready_i)
    );

    assign s_axi_awready_o = q.awrdy;
    assign s_axi_wready_o = q.wrdy;
    assign s_axi_bvalid_o = q.bv;
    assign s_axi_bresp_o = q.br;
    assign s_axi_arready_o = q.arrdy;
    assign s_axi_rvalid_o = q.rv;
    assign s_axi_rdata_o = q.rd;
    assign s_axi_rresp_o = q.rr;
    assign host_wait_o = q.hwait;
    assign host_mem16_o = q.ctrl[CT_MEM16];
    assign host_io16_o = q.ctrl[CT_IO16];
    assign mem_we_o = q.we;
    assign mem_addr_o = q.ma;
    assign mem_data_o = q.md;
    assign mem_plane_o = q.mp;
    assign mem_bitmask_o = q.mbm;
    assign row_xfer_o = q.rx;
    assign sclk_o = q.sclk;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence post_taken;
        host_wr_i && !host_wait_o;
    endsequence
    sequence commit_seen;
        mem_we_o && !host_wait_o;
    endsequence

    chk_dram_std_rate: assert property (
        disp_active_i && slot && !vram && res == RES_STD |-> q.cc[0] == 1'b0)
        else $error("DRAM standard slot off even phase");
    chk_dram_800_rate: assert property (
        disp_active_i && slot && !vram && res == RES_800 |-> q.cc == 2'h0)
        else $error("DRAM paged slot off fourth phase");
    chk_vram_every: assert property (
        disp_active_i && cclk_tick_i && vram && res == RES_STD |-> slot)
        else $error("VRAM slot missing on tick");
    chk_vram_1024: assert property (
        slot && disp_active_i && vram && res == RES_1024 |-> q.cc == 2'h0)
        else $error("VRAM 1024 slot off fourth phase");
    chk_retrace_free: assert property (
        !disp_active_i && !refresh_req_i && !q.rx_pend && q.wst != W_IDLE
        |=> mem_we_o)
        else $error("Idle retrace cycle not given to host");
    chk_row_steals: assert property (
        row_xfer_o |-> !mem_we_o && $past(slot))
        else $error("Row transfer outside slot or with host write");
    chk_posted_release: assert property (
        post_taken ##1 host_wait_o |-> ##[0:300] commit_seen)
        else $error("Posted write not committed in time");
    chk_masked_write: assert property (
        mem_we_o && $past(vram) |-> mem_bitmask_o == $past(q.bmask[7:0]))
        else $error("VRAM write mask not applied");
    chk_wait_hold: assert property (
        $fell(host_wait_o) |-> mem_we_o)
        else $error("Wait dropped before commit");
endmodule

/* dv/dmas_palette_model.sv */
// Palette sink model: accepts pixels on every other cycle, or not at all while stalled
`timescale 1ns/10ps
module dmas_palette_model (
    input  wire logic                      clk_sys_i,
    input  wire logic                      resetn_i,
    input  wire logic                      stall_i,
    input  wire logic                      pix_valid_i,
    input  wire logic [dmas_pkg::PIX_W-1:0] pix_i,
    output logic                           pix_ready_o
);
    import dmas_pkg::*;
    logic [PIX_W-1:0] got[$];
    logic             slow_reg;
    // Ready only on every other cycle, never while stalled
    assign pix_ready_o = !stall_i && slow_reg;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slow_reg <= 1'b0;
        end else begin
            slow_reg <= !slow_reg;
            if (pix_valid_i && pix_ready_o) begin
                got.push_back(pix_i);
            end
        end
    end
endmodule

/* dv/dmas_top_tb.sv */
// Self-checking bench of the display memory access scheduler
`timescale 1ns/10ps
module dmas_top_tb;
    import dmas_pkg::*;
    localparam logic [31:0] FGV = 32'hF0F0_FF00;
    localparam logic [31:0] BGV = 32'h0F33_00AA;
    logic        clk = 1'b0, rstn = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, mdata;
    logic        disp = 1'b0, tick = 1'b0, refr = 1'b0, lstart = 1'b0;
    logic        reload = 1'b0, hwr = 1'b0, hword = 1'b0, stall = 1'b0;
    logic [15:0] haddr = '0, hdata = '0;
    logic        hwait, m16, io16, we, rowx, sclk;
    logic [17:0] maddr;
    logic [3:0]  mplane;
    logic [7:0]  mmask, pixo, pixd = '0;
    logic [10:0] px = '0, py = '0;
    logic        pvin = 1'b0, prdy_o, pvout, prdy_i;
    logic [61:0] wq[$];
    int          n_fail = 0, num_checks = 0, n_we = 0, n_sclk = 0;
    int          n_row = 0, cyc = 0, t_row = 0, t_we = 0;

    always #4 clk = ~clk;

    dmas_top i_dmas_top (
        .clk_sys_i(clk), .resetn_i(rstn),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .disp_active_i(disp), .cclk_tick_i(tick),
        .refresh_req_i(refr), .line_start_i(lstart), .reload_i(reload),
        .host_wr_i(hwr), .host_word_i(hword), .host_addr_i(haddr),
        .host_data_i(hdata), .host_wait_o(hwait), .host_mem16_o(m16),
        .host_io16_o(io16), .mem_we_o(we), .mem_addr_o(maddr),
        .mem_data_o(mdata), .mem_plane_o(mplane), .mem_bitmask_o(mmask),
        .row_xfer_o(rowx), .sclk_o(sclk), .pix_valid_i(pvin),
        .pix_data_i(pixd), .pix_x_i(px), .pix_y_i(py),
        .pix_ready_o(prdy_o), .pix_valid_o(pvout), .pix_o(pixo),
        .pix_ready_i(prdy_i)
    );

    dmas_palette_model i_dmas_palette_model (
        .clk_sys_i(clk), .resetn_i(rstn), .stall_i(stall),
        .pix_valid_i(pvout), .pix_i(pixo), .pix_ready_o(prdy_i)
    );

    // Memory side monitor
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (we === 1'b1) begin
            n_we <= n_we + 1;
            t_we <= cyc;
            wq.push_back({maddr, mdata, mplane, mmask});
        end
        if (sclk === 1'b1) n_sclk <= n_sclk + 1;
        if (rowx === 1'b1) begin
            n_row <= n_row + 1;
            t_row <= cyc;
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        $display("CHECK FAILED t=%0t wait bound used up", $time);
        complete_run();
    endtask

    task automatic clks(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) hang();
        bready <= 1'b0;
        chk(bresp, er, "bresp");
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) hang();
        rready <= 1'b0;
        chk(rdata, ed, "rdata");
        chk(rresp, er, "rresp");
    endtask

    task automatic hw(input logic [15:0] a, d);
        haddr <= a;
        hdata <= d;
        hwr   <= 1'b1;
        @(posedge clk);
        hwr   <= 1'b0;
    endtask

    // Waits until no posted write is pending
    task automatic drain();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (hwait === 1'b0) break;
        end
        if (n == 40) hang();
        clks(2);
    endtask

    function automatic logic [31:0] fb(input logic [7:0] b);
        logic [31:0] r;
        int          p;
        for (p = 0; p < 4; p++) begin
            r[8*p +: 8] = (b & FGV[8*p +: 8]) | (~b & BGV[8*p +: 8]);
        end
        return r;
    endfunction

    task automatic t_regs();
        axr(OFS_CTRL, {23'h0, CTRL_RST}, RESP_OK);
        axr(OFS_BMASK, {20'h0, BMASK_RST}, RESP_OK);
        axr(OFS_PCOL, {24'h0, PCOL_RST}, RESP_OK);
        axw(OFS_STAT, 32'h1F, RESP_OK);
        axr(OFS_STAT, 32'h0, RESP_OK);
        axr(8'h40, 32'h0, RESP_ERR);
        axw(8'h40, 32'h1, RESP_ERR);
    endtask

    task automatic t_post();
        int b;
        refr <= 1'b1;
        b = n_we;
        hw(16'h0100, 16'h00A5);
        chk(hwait, 1'b0, "write taken without wait");
        clks(1);
        hw(16'h0200, 16'h005A);
        chk(hwait, 1'b1, "second write held off");
        clks(4);
        chk(n_we - b, 0, "refresh cycles kept");
        refr <= 1'b0;
        drain();
        chk(n_we - b, 1, "one write committed");
        chk(wq[$][61:44], 18'h00100, "posted addr");
        chk(wq[$][7:0], 8'hFF, "unmasked write");
    endtask

    task automatic t_rates();
        logic [2:0] md[5] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h5};
        int         mk[5] = '{1, 3, 0, 1, 3};
        int         i, k, bw, bs;
        for (i = 0; i < 5; i++) begin
            axw(OFS_CTRL, {29'h0, md[i]}, RESP_OK);
            disp <= 1'b1;
            hw(16'h0010, 16'h0033);
            bw = n_we;
            bs = n_sclk;
            for (k = 0; k < 24; k++) begin
                tick <= 1'b1;
                @(posedge clk);
                tick <= 1'b0;
                clks(2);
                if (hwait === 1'b0) hwr <= 1'b1;
                @(posedge clk);
                hwr <= 1'b0;
                clks(2);
            end
            @(posedge clk);
            chk(n_we - bw, 24 / (mk[i] + 1), "host slots");
            chk(n_sclk - bs, md[i][0] ? 24 : 0, "shift clocks");
            disp <= 1'b0;
            drain();
        end
    endtask

    task automatic t_rows();
        int br;
        axw(OFS_CTRL, 32'h1, RESP_OK);
        br = n_row;
        lstart <= 1'b1;
        @(posedge clk);
        lstart <= 1'b0;
        clks(4);
        chk(n_row - br, 1, "line start load");
        disp   <= 1'b1;
        reload <= 1'b1;
        hw(16'h0040, 16'h0011);
        reload <= 1'b0;
        repeat (3) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            clks(5);
        end
        chk(n_row - br, 2, "mid-line reload");
        chk(t_we > t_row, 1'b1, "reload before write");
        disp <= 1'b0;
        drain();
    endtask

    task automatic t_data();
        int b;
        axw(OFS_BMASK, 32'h53C, RESP_OK);
        axw(OFS_FGPAT, FGV, RESP_OK);
        axw(OFS_BGPAT, BGV, RESP_OK);
        axw(OFS_CTRL, 32'hB9, RESP_OK);
        axr(OFS_BMASK, 32'h53C, RESP_OK);
        chk({m16, io16}, 2'b11, "16-bit selects");
        b = wq.size();
        hword <= 1'b1;
        hw(16'h1230, 16'h96C3);
        drain();
        chk(wq.size() - b, 2, "word split");
        chk(wq[b][61:44], 18'h21230, "low byte addr");
        chk(wq[b+1][61:44], 18'h21231, "high byte addr");
        chk(wq[b][43:12], fb(8'hC3), "low expand");
        chk(wq[b+1][43:12], fb(8'h96), "high expand");
        chk(wq[b][11:0], 12'h53C, "planes and bit mask");
        axw(OFS_CTRL, 32'hB1, RESP_OK);
        clks(2);
        chk({m16, io16}, 2'b01, "io select alone");
        hw(16'h2000, 16'h7788);
        drain();
        chk(wq.size() - b, 3, "byte only");
        hword <= 1'b0;
    endtask

    task automatic sp(input logic [10:0] x, y, input logic [7:0] d);
        int n;
        px   <= x;
        py   <= y;
        pixd <= d;
        pvin <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (prdy_o) break;
        end
        if (n == 40) hang();
    endtask

    task automatic t_pix();
        logic [7:0] ex[4] = '{8'h5A, 8'h22, 8'h33, 8'h5A};
        int         n;
        axw(OFS_PPOS, {5'h0, 11'h014, 5'h0, 11'h00A}, RESP_OK);
        axw(OFS_PIDX, 32'h2, RESP_OK);
        axw(OFS_PROW, 32'h8, RESP_OK);
        axw(OFS_PCOL, 32'h5A, RESP_OK);
        axw(OFS_CTRL, 32'h100, RESP_OK);
        stall <= 1'b1;
        sp(11'h00D, 11'h016, 8'h11);
        sp(11'h00C, 11'h016, 8'h22);
        pvin <= 1'b0;
        clks(3);
        chk(prdy_o, 1'b0, "buffer full");
        stall <= 1'b0;
        sp(11'h00D, 11'h015, 8'h33);
        sp(11'h00D, 11'h016, 8'h44);
        pvin <= 1'b0;
        for (n = 0; n < 40 && i_dmas_palette_model.got.size() < 4; n++) begin
            @(posedge clk);
        end
        if (n == 40) hang();
        chk(i_dmas_palette_model.got.size(), 4, "pixels delivered");
        for (n = 0; n < 4; n++) begin
            chk(i_dmas_palette_model.got[n], ex[n], "pixel");
        end
    endtask

    initial begin
        clks(2);
        rstn <= 1'b1;
        t_regs();
        t_post();
        t_rates();
        t_rows();
        t_data();
        t_pix();
        complete_run();
    end
endmodule
